// file: ccu_pkg.sv
// Shared constants and types for the five-channel capture/compare unit
// Notes on behaviour
// - Five channels, mode bit picks capture/compare
// - Capture copies timer count on chosen edge
// - Events set flag; irq needs both enables
// - Select hi picks constant level; software capture
// - Selected input level readable at any time
// - Compare match latches selected input level
// - Sync bit aligns capture to timer clock
// - Second unread capture sets sticky overrun
// - Compare match sets flag, drives match signal
// - Channel zero matches at or above
// - Eight output modes from both matches
// - Mode zero follows output bit immediately
// - Other modes change on timer edge, or reset on timer clear
// - Mode one sets on match, holds
// - Mode two toggles, period match resets
// - Mode three sets, period match resets
// - Mode four toggles on each match
// - Mode five resets on match, holds
// - Mode six toggles, period match sets
// - Mode seven resets, period match sets
// - Matches sampled low, output updates rising
// - Up mode uses count-zero period event
package ccu_pkg;
    localparam int CCU_NCH = 5;
    localparam int CCU_TW = 16;
    localparam logic [1:0] CCU_EDGE_NONE = 2'h0;
    localparam logic [1:0] CCU_EDGE_RISE = 2'h1;
    localparam logic [1:0] CCU_EDGE_FALL = 2'h2;
    localparam logic [1:0] CCU_EDGE_BOTH = 2'h3;
    localparam logic [1:0] CCU_SEL_A = 2'h0;
    localparam logic [1:0] CCU_SEL_B = 2'h1;
    localparam logic [1:0] CCU_SEL_LOW = 2'h2;
    localparam logic [1:0] CCU_SEL_HIGH = 2'h3;
    localparam int CCU_SEL_HI_BIT = 1;
    localparam logic [15:0] CCU_RST_DATA = 16'h0000;
    localparam logic [15:0] CCU_COUNT_ZERO = 16'h0000;
    localparam logic CCU_RST_BIT = 1'b0;

    // Output waveform modes
    typedef enum logic [2:0] {
        CCU_OM_BIT = 3'b000,
        CCU_OM_SET = 3'b001,
        CCU_OM_TOG_RST = 3'b010,
        CCU_OM_SET_RST = 3'b011,
        CCU_OM_TOG = 3'b100,
        CCU_OM_RST = 3'b101,
        CCU_OM_TOG_SET = 3'b110,
        CCU_OM_RST_SET = 3'b111
    } ccu_om_t;
endpackage : ccu_pkg

// file: ccu_capture.sv
// Capture input selection, synchronisation and edge detection for one channel
`timescale 1ns/1ns
module ccu_capture import ccu_pkg::*; (
    input wire logic i_sys_clk, // System clock
    input wire logic i_srst, // Sync reset
    input wire logic i_tick, // Timer rising edge enable
    input wire logic i_in_a, // Capture input a pin
    input wire logic i_in_b, // Capture input b pin
    input wire logic [1:0] i_sel, // Input select field
    input wire logic [1:0] i_edge, // Capture edge field
    input wire logic i_sync_en, // Align capture to timer
    input wire logic i_cap_mode, // Capture mode
    output logic o_level, // Selected input level
    output logic o_capture // Capture pulse
);
    logic [1:0] a_sync_reg;
    logic [1:0] b_sync_reg;
    logic prev_reg;
    logic pend_reg;
    logic hit;

    // Pins pass two flops; the first stage feeds only the second
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            a_sync_reg <= 2'h0;
            b_sync_reg <= 2'h0;
        end else begin
            a_sync_reg <= {a_sync_reg[0], i_in_a};
            b_sync_reg <= {b_sync_reg[0], i_in_b};
        end
    end

    // Constant levels let software force captures
    always_comb begin
        if (i_sel[CCU_SEL_HI_BIT]) begin
            o_level = (i_sel == CCU_SEL_HIGH);
        end else if (i_sel == CCU_SEL_B) begin
            o_level = b_sync_reg[1];
        end else begin
            o_level = a_sync_reg[1];
        end
    end

    // Edge qualification
    always_comb begin
        hit = 1'b0;
        if (i_cap_mode) begin
            case (i_edge)
                CCU_EDGE_RISE: hit = o_level & ~prev_reg;
                CCU_EDGE_FALL: hit = ~o_level & prev_reg;
                CCU_EDGE_BOTH: hit = o_level ^ prev_reg;
                default: hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            prev_reg <= CCU_RST_BIT;
        end else begin
            prev_reg <= o_level;
        end
    end

    // Synced captures wait for the timer edge so count and event agree
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !i_sync_en || !i_cap_mode) begin
            pend_reg <= 1'b0;
        end else if (i_tick) begin
            pend_reg <= 1'b0;
        end else if (hit) begin
            pend_reg <= 1'b1;
        end
    end

    assign o_capture = i_sync_en ? (i_tick & (pend_reg | hit)) : hit;
endmodule : ccu_capture

// file: ccu_output_unit.sv
// Output waveform generator for one channel
`timescale 1ns/1ns
module ccu_output_unit import ccu_pkg::*; (
    input wire logic i_sys_clk, // System clock
    input wire logic i_srst, // Sync reset
    input wire logic i_tick, // Timer rising edge enable
    input wire logic i_timer_clr, // Timer reset
    input wire logic [2:0] i_mode, // Output mode field
    input wire logic i_out_bit, // Software output value
    input wire logic i_eq0, // Period event, sampled except in up mode
    input wire logic i_eqx, // Sampled channel match
    output logic o_out // Channel output flop
);
    logic out_next;

    // Next value per mode
    always_comb begin
        out_next = o_out;
        case (ccu_om_t'(i_mode))
            CCU_OM_SET: if (i_eqx) out_next = 1'b1;
            CCU_OM_TOG_RST: begin
                if (i_eq0) out_next = i_eqx;
                else if (i_eqx) out_next = ~o_out;
            end
            CCU_OM_SET_RST: begin
                if (i_eq0) out_next = i_eqx;
                else if (i_eqx) out_next = 1'b1;
            end
            CCU_OM_TOG: if (i_eqx) out_next = ~o_out;
            CCU_OM_RST: if (i_eqx) out_next = 1'b0;
            CCU_OM_TOG_SET: begin
                if (i_eq0) out_next = ~i_eqx;
                else if (i_eqx) out_next = ~o_out;
            end
            CCU_OM_RST_SET: begin
                if (i_eq0) out_next = ~i_eqx;
                else if (i_eqx) out_next = 1'b0;
            end
            default: out_next = i_out_bit;
        endcase
    end

    // Mode zero tracks the bit every cycle; others wait for the timer edge, but a timer clear resets them in any cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_out <= CCU_RST_BIT;
        end else if (i_mode == CCU_OM_BIT) begin
            o_out <= i_out_bit;
        end else if (i_timer_clr) begin
            o_out <= CCU_RST_BIT;
        end else if (i_tick) begin
            o_out <= out_next;
        end
    end
endmodule : ccu_output_unit

// file: ccu_top.sv
// Five capture/compare channels with output units beside a 16-bit timer
`timescale 1ns/1ns
module ccu_top import ccu_pkg::*; (
    input wire logic i_sys_clk, // 125 MHz clock
    input wire logic i_srst, // Sync reset, high
    input wire logic i_timer_tick, // Timer rising edge
    input wire logic [15:0] i_timer_count, // Timer count
    input wire logic i_up_mode, // Timer in up mode
    input wire logic i_timer_clr, // Timer cleared
    input wire logic i_global_irq_enable, // Global irq enable
    input wire logic [4:0] i_capture_select_bit, // 1 capture, 0 compare
    input wire logic [4:0][1:0] i_capture_edge, // Edge field
    input wire logic [4:0][1:0] i_input_select, // Input select
    input wire logic [4:0] i_capture_sync_enable, // Sync capture
    input wire logic [4:0] i_channel_irq_enable, // Channel irq enable
    input wire logic [4:0][2:0] i_output_mode_field, // Output mode
    input wire logic [4:0] i_out_bit, // Output value bit
    input wire logic [4:0] i_capture_input_a, // Input a pins
    input wire logic [4:0] i_capture_input_b, // Input b pins
    input wire logic [4:0] i_data_wr, // Data write strobe
    input wire logic [15:0] i_data_wdata, // Data write value
    input wire logic [4:0] i_data_rd, // Data read strobe
    input wire logic [4:0] i_flag_clr, // Event flag clear
    input wire logic [4:0] i_overrun_clr, // Overrun clear
    output logic [4:0][15:0] o_channel_data_register, // Data registers
    output logic [4:0] o_channel_event_flag, // Event flags
    output logic [4:0] o_capture_overrun_flag, // Overrun flags
    output logic [4:0] o_irq_req, // Interrupt requests
    output logic [4:0] o_selected_input_level, // Input level
    output logic [4:0] o_synced_input_latch, // Latched input
    output logic [4:0] o_channel_match, // Sampled matches
    output logic [4:0] o_channel_output // Output pins
);
    logic [4:0] cap;
    logic [4:0] level;
    logic [4:0] match_raw;
    logic [4:0] unread_reg;
    logic [4:0] flag_next;
    logic [4:0] set_evt;
    logic period_evt;

    // Up mode replaces the period match with a count-zero event
    assign period_evt = i_up_mode ? (i_timer_count == CCU_COUNT_ZERO)
                                  : o_channel_match[0];

    genvar ch;
    generate
        for (ch = 0; ch < CCU_NCH; ch++) begin : g_ch
            ccu_capture u_cap (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_tick(i_timer_tick),
                .i_in_a(i_capture_input_a[ch]),
                .i_in_b(i_capture_input_b[ch]),
                .i_sel(i_input_select[ch]),
                .i_edge(i_capture_edge[ch]),
                .i_sync_en(i_capture_sync_enable[ch]),
                .i_cap_mode(i_capture_select_bit[ch]),
                .o_level(level[ch]),
                .o_capture(cap[ch])
            );

            ccu_output_unit u_out (
                .i_sys_clk(i_sys_clk),
                .i_srst(i_srst),
                .i_tick(i_timer_tick),
                .i_timer_clr(i_timer_clr),
                .i_mode(i_output_mode_field[ch]),
                .i_out_bit(i_out_bit[ch]),
                .i_eq0(period_evt),
                .i_eqx(o_channel_match[ch]),
                .o_out(o_channel_output[ch])
            );

            // Channel zero compares at-or-above so a short period still wraps
            if (ch == 0) begin : g_ge
                assign match_raw[ch] = i_timer_count >= o_channel_data_register[ch];
            end else begin : g_eq
                assign match_raw[ch] = i_timer_count == o_channel_data_register[ch];
            end

            // Match sampled in the low phase, held across the rising edge
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_channel_match[ch] <= CCU_RST_BIT;
                end else if (!i_timer_tick) begin
                    o_channel_match[ch] <= match_raw[ch] & ~i_capture_select_bit[ch];
                end
            end

            // Capture wins over a software write in the same cycle
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_channel_data_register[ch] <= CCU_RST_DATA;
                end else if (cap[ch]) begin
                    o_channel_data_register[ch] <= i_timer_count;
                end else if (i_data_wr[ch]) begin
                    o_channel_data_register[ch] <= i_data_wdata;
                end
            end

            // Event sources: capture, or compare match at the timer edge
            assign set_evt[ch] = cap[ch] | (i_timer_tick & o_channel_match[ch]);
            // Set beats clear when both land together
            assign flag_next[ch] = set_evt[ch] | (o_channel_event_flag[ch] & ~i_flag_clr[ch]);

            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_channel_event_flag[ch] <= CCU_RST_BIT;
                    o_irq_req[ch] <= CCU_RST_BIT;
                end else begin
                    o_channel_event_flag[ch] <= flag_next[ch];
                    o_irq_req[ch] <= flag_next[ch] & i_channel_irq_enable[ch] & i_global_irq_enable;
                end
            end

            // Unread tracking; a new capture beats a read in the same cycle
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    unread_reg[ch] <= CCU_RST_BIT;
                end else if (cap[ch]) begin
                    unread_reg[ch] <= 1'b1;
                end else if (i_data_rd[ch]) begin
                    unread_reg[ch] <= 1'b0;
                end
            end

            // Sticky overrun; only software clears it, and a new overrun wins
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_capture_overrun_flag[ch] <= CCU_RST_BIT;
                end else if (cap[ch] & unread_reg[ch] & ~i_data_rd[ch]) begin
                    o_capture_overrun_flag[ch] <= 1'b1;
                end else if (i_overrun_clr[ch]) begin
                    o_capture_overrun_flag[ch] <= 1'b0;
                end
            end

            // Level status and compare-time latch of the input
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    o_selected_input_level[ch] <= CCU_RST_BIT;
                    o_synced_input_latch[ch] <= CCU_RST_BIT;
                end else begin
                    o_selected_input_level[ch] <= level[ch];
                    if (match_raw[ch] & ~o_channel_match[ch] & ~i_capture_select_bit[ch] & ~i_timer_tick) begin
                        o_synced_input_latch[ch] <= level[ch];
                    end
                end
            end

            property p_capture_copy;
                @(posedge i_sys_clk) disable iff (i_srst)
                cap[ch] |=> o_channel_data_register[ch] == $past(i_timer_count);
            endproperty
            a_capture_copy: assert property (p_capture_copy) else $error("capture lost count");

            property p_event_irq;
                @(posedge i_sys_clk) disable iff (i_srst)
                set_evt[ch] && i_channel_irq_enable[ch] && i_global_irq_enable |=> o_irq_req[ch];
            endproperty
            a_event_irq: assert property (p_event_irq) else $error("enabled event raised no irq");

            property p_irq_gated;
                @(posedge i_sys_clk) disable iff (i_srst)
                o_irq_req[ch] |-> o_channel_event_flag[ch] && $past(i_global_irq_enable);
            endproperty
            a_irq_gated: assert property (p_irq_gated) else $error("irq without flag or enable");

            property p_overrun;
                @(posedge i_sys_clk) disable iff (i_srst)
                cap[ch] ##1 (!i_data_rd[ch])[*2] ##0 cap[ch] |=> o_capture_overrun_flag[ch];
            endproperty
            a_overrun: assert property (p_overrun) else $error("second capture missed overrun");

            property p_overrun_sticky;
                @(posedge i_sys_clk) disable iff (i_srst)
                o_capture_overrun_flag[ch] && !i_overrun_clr[ch] |=> o_capture_overrun_flag[ch];
            endproperty
            a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun dropped alone");

            property p_compare_flag;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[ch] |=> o_channel_event_flag[ch];
            endproperty
            a_compare_flag: assert property (p_compare_flag) else $error("match set no flag");

            property p_mode0;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_output_mode_field[ch] == CCU_OM_BIT |=> o_channel_output[ch] == $past(i_out_bit[ch]);
            endproperty
            a_mode0: assert property (p_mode0) else $error("mode zero output lags bit");

            property p_edge_only;
                @(posedge i_sys_clk) disable iff (i_srst)
                !i_timer_tick && !i_timer_clr && i_output_mode_field[ch] != CCU_OM_BIT
                && $stable(i_output_mode_field[ch]) |=> $stable(o_channel_output[ch]);
            endproperty
            a_edge_only: assert property (p_edge_only) else $error("output moved off timer edge");

            property p_mode1;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[ch] && !i_timer_clr
                && i_output_mode_field[ch] == CCU_OM_SET |=> o_channel_output[ch];
            endproperty
            a_mode1: assert property (p_mode1) else $error("set mode did not set");

            property p_mode5;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[ch] && !i_timer_clr
                && i_output_mode_field[ch] == CCU_OM_RST |=> !o_channel_output[ch];
            endproperty
            a_mode5: assert property (p_mode5) else $error("reset mode did not reset");

            property p_mode4;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[ch] && !i_timer_clr
                && i_output_mode_field[ch] == CCU_OM_TOG |=> o_channel_output[ch] != $past(o_channel_output[ch]);
            endproperty
            a_mode4: assert property (p_mode4) else $error("toggle mode held");

            // Period match alone ends the pulse in the reset-type PWM modes
            property p_mode2;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[0] && !o_channel_match[ch] && !i_timer_clr && !i_up_mode
                && (i_output_mode_field[ch] == CCU_OM_TOG_RST || i_output_mode_field[ch] == CCU_OM_SET_RST)
                |=> !o_channel_output[ch];
            endproperty
            a_mode2: assert property (p_mode2) else $error("period match did not reset");

            property p_mode6;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[0] && !o_channel_match[ch] && !i_timer_clr && !i_up_mode
                && (i_output_mode_field[ch] == CCU_OM_TOG_SET || i_output_mode_field[ch] == CCU_OM_RST_SET)
                |=> o_channel_output[ch];
            endproperty
            a_mode6: assert property (p_mode6) else $error("period match did not set");

            property p_level;
                @(posedge i_sys_clk) disable iff (i_srst)
                i_input_select[ch] == CCU_SEL_HIGH ##1 i_input_select[ch] == CCU_SEL_HIGH
                |=> o_selected_input_level[ch];
            endproperty
            a_level: assert property (p_level) else $error("forced high not shown");

            c_capture: cover property (@(posedge i_sys_clk) disable iff (i_srst) cap[ch]);
            c_overrun: cover property (@(posedge i_sys_clk) disable iff (i_srst)
                $rose(o_capture_overrun_flag[ch]));
            c_compare_out: cover property (@(posedge i_sys_clk) disable iff (i_srst)
                i_timer_tick && o_channel_match[ch] && i_output_mode_field[ch] == CCU_OM_TOG_RST);
        end
    endgenerate

    property p_period_ge;
        @(posedge i_sys_clk) disable iff (i_srst)
        !i_timer_tick && !i_capture_select_bit[0] && i_timer_count > o_channel_data_register[0]
        |=> o_channel_match[0];
    endproperty
    a_period_ge: assert property (p_period_ge) else $error("period match missed above value");

    property p_up_zero;
        @(posedge i_sys_clk) disable iff (i_srst)
        i_up_mode && i_timer_tick && !i_timer_clr && i_timer_count == CCU_COUNT_ZERO && !o_channel_match[3]
        && (i_output_mode_field[3] == CCU_OM_TOG_SET || i_output_mode_field[3] == CCU_OM_RST_SET)
        |=> o_channel_output[3];
    endproperty
    a_up_zero: assert property (p_up_zero) else $error("up mode zero event missing");
endmodule : ccu_top

// file: ccu_timer_model.sv
// Timer counter partner model: tick pulse and a count that wraps at a top value
`timescale 1ns/1ns
module ccu_timer_model #(
    parameter int DIV = 4
) (
    input wire logic i_sys_clk, // Clock
    input wire logic i_srst, // Sync reset
    input wire logic i_run, // Count enable
    input wire logic [15:0] i_top, // Wrap value
    output logic o_tick, // Timer rising edge
    output logic [15:0] o_count // Count value
);
    int div_reg;
    // Tick every DIV cycles so a low phase always exists between ticks
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            div_reg <= 0;
            o_tick <= 1'b0;
            o_count <= 16'h0000;
        end else begin
            o_tick <= i_run && (div_reg == DIV - 1);
            div_reg <= (div_reg == DIV - 1) ? 0 : div_reg + 1;
            if (o_tick) begin
                o_count <= (o_count >= i_top) ? 16'h0000 : o_count + 16'h0001;
            end
        end
    end
endmodule : ccu_timer_model

// file: testbench.sv
// Self-checking bench: compare waveforms against a reference, then captures
`timescale 1ns/1ns
module testbench import ccu_pkg::*;;
    logic clk = 0, srst = 1, run = 0, clr = 0, global_irq_enable = 1, tick, tick_d;
    logic [15:0] cnt, cnt_d, wd = 16'h0000;
    logic [4:0] capsel = 0, sync = 0, ie = 5'h1f, ob = 0, pa = 0, pb = 0, wr = 0, rd = 0, fclr = 0, oclr = 0;
    logic [4:0][1:0] edg = 0, isel = 0;
    logic [4:0][2:0] om = 0;
    logic [4:0][15:0] dr = 0, data;
    logic [4:0] flag, ovr, irq, lvl, slat, match, outp, eq_r = 0, out_r = 0, fl_r = 0, irq_r = 0;
    logic fn, chk_on = 0, up = 0;
    int error_cnt = 0, comparisons = 0;
    always #4 clk = ~clk;
    ccu_timer_model #(.DIV(4)) u_ccu_timer_model (.i_sys_clk(clk), .i_srst(srst), .i_run(run),
        .i_top(dr[0]), .o_tick(tick), .o_count(cnt));
    ccu_top u_ccu_top (.i_sys_clk(clk), .i_srst(srst), .i_timer_tick(tick), .i_timer_count(cnt),
        .i_up_mode(up), .i_timer_clr(clr), .i_global_irq_enable(global_irq_enable), .i_capture_select_bit(capsel),
        .i_capture_edge(edg), .i_input_select(isel), .i_capture_sync_enable(sync),
        .i_channel_irq_enable(ie), .i_output_mode_field(om), .i_out_bit(ob), .i_capture_input_a(pa),
        .i_capture_input_b(pb), .i_data_wr(wr), .i_data_wdata(wd), .i_data_rd(rd), .i_flag_clr(fclr),
        .i_overrun_clr(oclr), .o_channel_data_register(data), .o_channel_event_flag(flag),
        .o_capture_overrun_flag(ovr), .o_irq_req(irq), .o_selected_input_level(lvl),
        .o_synced_input_latch(slat), .o_channel_match(match), .o_channel_output(outp));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // Next output value from the mode table
    function automatic logic nxt(input logic [2:0] m, input logic e0, input logic ex, input logic o);
        case (m)
            3'h1: return ex ? 1'b1 : o;
            3'h2: return e0 ? ex : (ex ? ~o : o);
            3'h3: return e0 ? ex : (ex ? 1'b1 : o);
            3'h4: return ex ? ~o : o;
            3'h5: return ex ? 1'b0 : o;
            3'h6: return e0 ? ~ex : (ex ? ~o : o);
            default: return e0 ? ~ex : (ex ? 1'b0 : o);
        endcase
    endfunction : nxt
    // Reference for compare channels: sample matches off-tick, update on tick
    always @(posedge clk) begin
        tick_d <= tick;
        cnt_d <= cnt;
        for (int c = 0; c < 5; c++) begin
            fn = fl_r[c];
            if (fclr[c]) fn = 1'b0;
            if (tick && eq_r[c]) fn = 1'b1;
            if (!tick) eq_r[c] <= (c == 0) ? (cnt >= dr[0]) : (cnt == dr[c]);
            if (om[c] == 3'h0) out_r[c] <= ob[c];
            else if (clr) out_r[c] <= 1'b0;
            else if (tick) out_r[c] <= nxt(om[c], up ? (cnt == 16'h0000) : eq_r[0], eq_r[c], out_r[c]);
            fl_r[c] <= srst ? 1'b0 : fn;
            irq_r[c] <= srst ? 1'b0 : fn & ie[c] & global_irq_enable;
            if (srst) {eq_r[c], out_r[c]} <= 2'b00;
        end
    end
    // Compare-mode channels are checked on every falling edge
    always @(negedge clk) begin
        if (chk_on) for (int c = 0; c < 5; c++) if (!capsel[c]) begin
            check($sformatf("output %0d", c), outp[c], out_r[c]);
            check($sformatf("flag %0d", c), flag[c], fl_r[c]);
            check($sformatf("irq %0d", c), irq[c], irq_r[c]);
            check($sformatf("match %0d", c), match[c], eq_r[c]);
        end
    end
    task automatic write_reg(input int c, input logic [15:0] v);
        @(posedge clk);
        wr <= 5'h01 << c;
        wd <= v;
        @(posedge clk);
        // Reference copy moves on the edge the register takes the write
        dr[c] <= v;
        wr <= 5'h00;
    endtask : write_reg
    // Waits for the event flag, then checks captured count and overrun
    task automatic cap_wait(input int c, input logic exp_ovr);
        int n;
        n = 0;
        @(negedge clk);
        while (flag[c] !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check("capture flag", flag[c], 1'b1);
        check("capture data", data[c], cnt_d);
        check("capture irq", irq[c], 1'b1);
        check("overrun", ovr[c], exp_ovr);
    endtask : cap_wait
    task automatic clear_all();
        @(posedge clk);
        {rd, fclr, oclr} <= {3{5'h1f}};
        @(posedge clk);
        {rd, fclr, oclr} <= 15'h0000;
        repeat (2) @(posedge clk);
    endtask : clear_all
    initial begin
        #20000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("reset flags", {1'b0, flag, ovr, irq}, 16'h0000);
        check("reset pins", {6'h00, outp, match}, 16'h0000);
        check("reset data", data[2], CCU_RST_DATA);
        write_reg(0, 16'h0014);
        write_reg(1, 16'h0005);
        write_reg(2, 16'h000a);
        write_reg(3, 16'h000f);
        write_reg(4, 16'h0013);
        isel[2] <= CCU_SEL_HIGH;
        run <= 1'b1;
        chk_on <= 1'b1;
        // Channel zero only gets modes that make sense there
        om <= {3'h7, 3'h3, 3'h2, 3'h1, 3'h4};
        repeat (150) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (100) @(posedge clk);
        om <= {3'h0, 3'h6, 3'h5, 3'h4, 3'h5};
        up <= 1'b1; // Period event from count zero
        ob <= 5'h10;
        global_irq_enable <= 1'b0;
        clear_all();
        repeat (180) @(posedge clk);
        check("synced latch", slat[2], 1'b1);
        check("input level", lvl[2], 1'b1);
        $display("Compare and output tests done");
        // Software capture on channel 1, pin capture on channel 3
        global_irq_enable <= 1'b1;
        capsel <= 5'h0a;
        edg[1] <= CCU_EDGE_BOTH;
        isel[1] <= CCU_SEL_LOW;
        edg[3] <= CCU_EDGE_RISE;
        sync[3] <= 1'b1;
        clear_all();
        isel[1] <= CCU_SEL_HIGH;
        cap_wait(1, 1'b0);
        @(posedge clk);
        isel[1] <= CCU_SEL_LOW;
        repeat (6) @(posedge clk);
        check("second capture overrun", ovr[1], 1'b1);
        check("second capture data", data[1] <= cnt, 1'b1);
        clear_all();
        check("overrun cleared", ovr[1], 1'b0);
        pa[3] <= 1'b1;
        cap_wait(3, 1'b0);
        check("capture on tick", tick_d, 1'b1);
        check("pin level", lvl[3], 1'b1);
        edg[3] <= CCU_EDGE_FALL;
        clear_all();
        pa[3] <= 1'b0;
        cap_wait(3, 1'b0);
        edg[3] <= CCU_EDGE_NONE;
        isel[3] <= CCU_SEL_B;
        clear_all();
        pb[3] <= 1'b1;
        repeat (20) @(posedge clk);
        check("no capture edge none", flag[3], 1'b0);
        check("input b level", lvl[3], 1'b1);
        $display("Capture tests done");
        chk_on <= 1'b0;
        capsel <= 5'h00; // Captures off before the timer halts
        @(posedge clk);
        run <= 1'b0;
        stop_test();
    end
endmodule : testbench
